// File: inc/cfg_pkg.sv
// Constants and carrier types for the device configuration bank.
// Assumes an 8-bit register port in the REF_CLK domain.
package cfg_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_IRQ_PIN_CFG = 8'h7D;
  localparam logic [7:0] ADDR_WP_KEY      = 8'h7E;
  localparam logic [7:0] ADDR_HOST_SEL    = 8'h7F;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_IRQ_PIN_CFG = 8'h02;
  localparam logic [7:0] RST_WP_KEY      = 8'h85;
  localparam logic [7:0] RST_HOST_SEL    = 8'h00;
  localparam int         BIT_POLARITY    = 0;
  localparam int         BIT_IDLE_FLOAT  = 1;
  localparam int         BIT_AUX_OUT     = 2;
  localparam int         IRQ_CFG_W       = 3;
  localparam int         HOST_SEL_W      = 3;

  // ----------------------------------------
  // Key codes and host-port styles
  // ----------------------------------------
  localparam logic [7:0] KEY_UNPROT = 8'h85;
  localparam logic [7:0] KEY_SINGLE = 8'h86;
  localparam logic [2:0] HS_EPROM   = 3'h1;
  localparam logic [2:0] HS_MUX     = 3'h2;
  localparam logic [2:0] HS_PAR_A   = 3'h3;
  localparam logic [2:0] HS_PAR_B   = 3'h4;
  localparam logic [2:0] HS_SERIAL  = 3'h5;

  typedef enum logic [2:0] {
    WP_LOCKED = 3'b001,
    WP_OPEN   = 3'b010,
    WP_SINGLE = 3'b100
  } wp_mode_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe_b;
  } pin_drv_t;
endpackage

// File: design/irq_pin_drv.sv
// Interrupt pin shaping: polarity, idle float and auxiliary output use.
// Assumes a core interrupt level in the REF_CLK domain.
`timescale 1ns/1ps
`default_nettype none
module irq_pin_drv
  import cfg_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic [IRQ_CFG_W-1:0] cfg,
  input  wire logic                 irq_active,
  output var  pin_drv_t             pin
);
  typedef struct packed {
    pin_drv_t pin;
  } st_t;
  st_t st_q;
  st_t st_d;

  always_comb begin
    st_d = st_q;
    if (cfg[BIT_AUX_OUT]) begin
      st_d.pin.out  = cfg[BIT_POLARITY];
      st_d.pin.oe_b = 1'b0;
    end else begin
      st_d.pin.out  = irq_active ? cfg[BIT_POLARITY] : ~cfg[BIT_POLARITY];
      st_d.pin.oe_b = cfg[BIT_IDLE_FLOAT] & ~irq_active;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{pin: '{out: 1'b1, oe_b: 1'b1}};
    end else begin
      st_q <= st_d;
    end
  end

  assign pin = st_q.pin;

  chk_aux_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg[BIT_AUX_OUT] |=> (pin.out == $past(cfg[BIT_POLARITY])) && !pin.oe_b)
    else $error("aux output level wrong");
  chk_float_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!cfg[BIT_AUX_OUT] && cfg[BIT_IDLE_FLOAT] && !irq_active) |=> pin.oe_b)
    else $error("idle pin not floated");
  chk_drive_always: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!cfg[BIT_AUX_OUT] && !cfg[BIT_IDLE_FLOAT]) |=> !pin.oe_b)
    else $error("pin not driven");
  chk_active_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!cfg[BIT_AUX_OUT] && irq_active) |=> pin.out == $past(cfg[BIT_POLARITY]))
    else $error("active level wrong");
  cov_float_irq: cover property (@(posedge ref_clk) disable iff (!rst_b)
    cfg[BIT_IDLE_FLOAT] && !irq_active ##1 irq_active);
endmodule
`default_nettype wire

// File: design/dev_cfg_bank.sv
// Device configuration bank: interrupt pin setup, write protection, host port
// selection and boundary-scan test reset handling.
// Assumes a synchronous 8-bit register port and strap pins stable at reset.
`timescale 1ns/1ps
`default_nettype none
module dev_cfg_bank
  import cfg_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [2:0]  HOST_STRAP,
  input  wire logic        IRQ_ACTIVE,
  output logic             IRQ_PIN_OUT,
  output logic             IRQ_PIN_OE_B,
  output logic [2:0]       HOST_STYLE,
  output logic             HOST_STYLE_VALID,
  output logic             WRITES_OPEN,
  input  wire logic        TEST_RST_IN,
  output logic             TEST_RST_PULL_LOW,
  output logic             SCAN_MODE,
  output logic             SCAN_CORE_CAPTURE
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [IRQ_CFG_W-1:0]  irq_cfg;
    logic [7:0]            key;
    wp_mode_t              mode;
    logic [HOST_SEL_W-1:0] host_sel;
    logic                  strap_done;
    logic [7:0]            rdata;
    logic                  scan;
    logic                  wr_open;
  } st_t;
  st_t      st_q;
  st_t      st_d;
  reg_req_t req;
  pin_drv_t pin;
  logic     wr_other;
  logic     allowed;

  assign req      = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
  assign wr_other = req.wr && (req.addr != ADDR_WP_KEY);
  assign allowed  = (st_q.mode != WP_LOCKED);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (!st_q.strap_done) begin
      st_d.host_sel   = HOST_STRAP;
      st_d.strap_done = 1'b1;
    end
    if (wr_other && allowed && st_q.strap_done) begin
      if (req.addr == ADDR_IRQ_PIN_CFG) begin
        st_d.irq_cfg = req.wdata[IRQ_CFG_W-1:0];
      end
      if (req.addr == ADDR_HOST_SEL && st_q.host_sel == HS_EPROM) begin
        st_d.host_sel = req.wdata[HOST_SEL_W-1:0];
      end
    end
    if (wr_other && st_q.mode == WP_SINGLE) begin
      st_d.mode = WP_LOCKED;
      st_d.key  = 8'h00;
    end
    if (req.wr && req.addr == ADDR_WP_KEY) begin
      st_d.key = req.wdata;
      case (req.wdata)
        KEY_UNPROT: st_d.mode = WP_OPEN;
        KEY_SINGLE: st_d.mode = WP_SINGLE;
        default:    st_d.mode = WP_LOCKED;
      endcase
    end
    case (req.addr)
      ADDR_IRQ_PIN_CFG: st_d.rdata = {5'h00, st_q.irq_cfg};
      ADDR_WP_KEY:      st_d.rdata = st_q.key;
      ADDR_HOST_SEL:    st_d.rdata = {5'h00, st_q.host_sel};
      default:          st_d.rdata = 8'h00;
    endcase
    st_d.scan    = TEST_RST_IN;
    st_d.wr_open = (st_d.mode != WP_LOCKED);
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q.irq_cfg    <= RST_IRQ_PIN_CFG[IRQ_CFG_W-1:0];
      st_q.key        <= RST_WP_KEY;
      st_q.mode       <= WP_OPEN;
      st_q.host_sel   <= RST_HOST_SEL[HOST_SEL_W-1:0];
      st_q.strap_done <= 1'b0;
      st_q.rdata      <= 8'h00;
      st_q.scan       <= 1'b0;
      st_q.wr_open    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  irq_pin_drv u_irq_pin (
    .ref_clk    (REF_CLK),
    .rst_b      (RST_B),
    .cfg        (st_q.irq_cfg),
    .irq_active (IRQ_ACTIVE),
    .pin        (pin)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign REG_RDATA         = st_q.rdata;
  assign IRQ_PIN_OUT       = pin.out;
  assign IRQ_PIN_OE_B      = pin.oe_b;
  assign HOST_STYLE        = st_q.host_sel;
  assign HOST_STYLE_VALID  = st_q.strap_done;
  assign WRITES_OPEN       = st_q.wr_open;
  assign TEST_RST_PULL_LOW = 1'b1;
  assign SCAN_MODE         = st_q.scan;
  assign SCAN_CORE_CAPTURE = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_locked_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_q.mode == WP_LOCKED && wr_other && req.addr == ADDR_IRQ_PIN_CFG)
      |=> $stable(st_q.irq_cfg))
    else $error("write passed while locked");
  chk_key_decode: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (req.wr && req.addr == ADDR_WP_KEY && req.wdata == KEY_SINGLE)
      |=> st_q.mode == WP_SINGLE)
    else $error("single key not decoded");
  chk_single_once: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_q.mode == WP_SINGLE && wr_other) |=> st_q.mode == WP_LOCKED)
    else $error("single mode not closed");
  chk_strap_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_q.strap_done && !(wr_other && req.addr == ADDR_HOST_SEL)) |=> $stable(st_q.host_sel))
    else $error("host select changed");
  chk_eprom_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (allowed && st_q.strap_done && st_q.host_sel != HS_EPROM && wr_other
      && req.addr == ADDR_HOST_SEL) |=> $stable(st_q.host_sel))
    else $error("host select written outside boot");
  chk_no_capture: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !SCAN_CORE_CAPTURE && TEST_RST_PULL_LOW)
    else $error("scan capture or pull wrong");
  chk_scan_follow: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    TEST_RST_IN |=> SCAN_MODE)
    else $error("scan mode not entered");
  cov_single: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    st_q.mode == WP_SINGLE ##1 st_q.mode == WP_LOCKED);
  cov_boot_switch: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    st_q.host_sel == HS_EPROM ##1 st_q.host_sel == HS_SERIAL);
  cov_aux: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    st_q.irq_cfg[BIT_AUX_OUT]);
endmodule
`default_nettype wire

// File: dv/host_port_model.sv
// Host side of the register port and the test controller's reset pin.
// Assumes requests arrive from the bench just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_port_model
  import cfg_pkg::*;
(
  input  wire logic       scan_on,
  input  var  reg_req_t   req,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            test_rst
);
  // Request held until the next falling edge, across the sampling edge
  assign reg_wr    = req.wr;
  assign reg_addr  = req.addr;
  assign reg_wdata = req.wdata;
  // Test reset high only while scan is wanted
  assign test_rst  = scan_on;
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the configuration bank.
// Assumes cfg_pkg and the design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, g); n_errors++; end end
module testbench;
  import cfg_pkg::*;
  logic       ref_clk, rst_b, irq_active, scan_on, reg_wr, test_rst;
  logic       pin_out, pin_oe_b, style_valid, writes_open, pull_low, scan_mode, core_cap;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [2:0] strap, style;
  reg_req_t   req;
  int         n_errors = 0;
  int         check_count = 0;
  // ----------------------------------------
  // Pin rows: cfg, irq, pin level, active-low enable (oe_b)
  // ----------------------------------------
  logic [5:0] rows [13] = '{6'b000010, 6'b000100, 6'b001000, 6'b001110, 6'b010011,
    6'b010100, 6'b011001, 6'b011110, 6'b100000, 6'b100100, 6'b101010, 6'b110100, 6'b111010};
  logic [7:0] bad [4] = '{8'h00, 8'h84, 8'h87, 8'hFF};
  logic [2:0] codes [4] = '{HS_MUX, HS_PAR_A, HS_PAR_B, HS_SERIAL};

  host_port_model host (.scan_on(scan_on), .req(req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .test_rst(test_rst));
  dev_cfg_bank uut (.REF_CLK(ref_clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .HOST_STRAP(strap), .IRQ_ACTIVE(irq_active),
    .IRQ_PIN_OUT(pin_out), .IRQ_PIN_OE_B(pin_oe_b), .HOST_STYLE(style),
    .HOST_STYLE_VALID(style_valid), .WRITES_OPEN(writes_open), .TEST_RST_IN(test_rst),
    .TEST_RST_PULL_LOW(pull_low), .SCAN_MODE(scan_mode), .SCAN_CORE_CAPTURE(core_cap));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bus and run control
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk) req = '{1'b1, a, d};
    @(negedge ref_clk) req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk) req.addr = a;
    @(negedge ref_clk) `CHK("rdata", e, rdata)
  endtask

  // Straps change right after capture to show they are ignored later
  task automatic do_reset(input logic [2:0] s);
    rst_b = 1'b0;
    strap = s;
    repeat (6) @(negedge ref_clk);
    `CHK("valid_rst", 1'b0, style_valid)
    `CHK("oe_b_rst", 1'b1, pin_oe_b)
    `CHK("open_rst", 1'b1, writes_open)
    rst_b = 1'b1;
    @(negedge ref_clk) strap = ~s;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    irq_active = 1'b0;
    scan_on = 1'b0;
    strap = HS_EPROM;
    req = '0;
    do_reset(HS_EPROM);
    @(negedge ref_clk) `CHK("style", HS_EPROM, style)
    `CHK("valid", 1'b1, style_valid)
    `CHK("pull_low", 1'b1, pull_low)
    `CHK("core_capture", 1'b0, core_cap)
    rd(ADDR_IRQ_PIN_CFG, RST_IRQ_PIN_CFG);
    rd(ADDR_WP_KEY, RST_WP_KEY);
    rd(ADDR_HOST_SEL, {5'h0, HS_EPROM});
    foreach (rows[i]) begin
      wr(ADDR_IRQ_PIN_CFG, {5'h1F, rows[i][5:3]});
      irq_active = rows[i][2];
      rd(ADDR_IRQ_PIN_CFG, {5'h0, rows[i][5:3]});
      `CHK("pin_out", rows[i][1], pin_out)
      `CHK("pin_oe_b", rows[i][0], pin_oe_b)
    end
    // ----------------------------------------
    // Write protection
    // ----------------------------------------
    foreach (bad[i]) begin
      wr(ADDR_WP_KEY, bad[i]);
      wr(ADDR_IRQ_PIN_CFG, 8'h00);
      rd(ADDR_IRQ_PIN_CFG, 8'h07);
      `CHK("writes_open", 1'b0, writes_open)
    end
    wr(ADDR_WP_KEY, KEY_SINGLE);
    rd(ADDR_WP_KEY, KEY_SINGLE);
    `CHK("writes_open", 1'b1, writes_open)
    wr(ADDR_IRQ_PIN_CFG, 8'h05);
    wr(ADDR_IRQ_PIN_CFG, 8'h00);
    rd(ADDR_IRQ_PIN_CFG, 8'h05);
    rd(ADDR_WP_KEY, 8'h00);
    wr(ADDR_WP_KEY, KEY_SINGLE);
    wr(8'h10, 8'h01);
    wr(ADDR_IRQ_PIN_CFG, 8'h00);
    rd(ADDR_IRQ_PIN_CFG, 8'h05);
    rd(8'h10, 8'h00);
    // ----------------------------------------
    // Host port selection and scan mode
    // ----------------------------------------
    wr(ADDR_WP_KEY, KEY_UNPROT);
    wr(ADDR_HOST_SEL, {5'h0, HS_SERIAL});
    wr(ADDR_HOST_SEL, {5'h0, HS_MUX});
    rd(ADDR_HOST_SEL, {5'h0, HS_SERIAL});
    `CHK("style", HS_SERIAL, style)
    foreach (codes[i]) begin
      do_reset(codes[i]);
      wr(ADDR_HOST_SEL, {5'h0, HS_EPROM});
      rd(ADDR_HOST_SEL, {5'h0, codes[i]});
      `CHK("style", codes[i], style)
    end
    scan_on = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("scan_mode", 1'b1, scan_mode)
    scan_on = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("scan_mode", 1'b0, scan_mode)
    finish_test();
  end
endmodule
`default_nettype wire
